// ### hw/mfsf_map.svh
// Offsets, bit positions, reset values of the memory fault status byte.
// Assumes the including file is compiled after mfsf_pkg.
// Summary of operation
// - Valid flag set only with captured address
// - All flags reset 0, write-one clears
// - Bits 6:5 and 2 read zero
// - Bit 4 set on stacking violation
// - Stacking violation: SP adjusted, no address capture
// - Bit 3 set on unstacking violation
// - Unstacking violation: no SP change, no capture
// - Bit 1 set on data access violation
// - Data violation captures access address
// - Bit 0 set on fetch violation, no capture
// - Execute-never fetch faults even protection off
// - Address valid flag sits at bit 7
`ifndef MFSF_MAP_SVH
`define MFSF_MAP_SVH
`define MFSF_ADDR_W 4
`define MFSF_OFF_STATUS 4'h0
`define MFSF_OFF_ADDR 4'h4
`define MFSF_BIT_VALID 7
`define MFSF_BIT_STK 4
`define MFSF_BIT_UNSTK 3
`define MFSF_BIT_DATA 1
`define MFSF_BIT_FETCH 0
`define MFSF_RST_STATUS 8'h00
`define MFSF_RST_ADDR 32'h0000_0000
`define MFSF_RSVD_MASK 8'h64
`endif

// ### hw/mfsf_pkg.sv
// Types for the memory fault status flags block.
// Assumes nothing beyond a SystemVerilog compiler.
package mfsf_pkg;
    // Fault events reported by the core in one cycle
    typedef struct packed {
        logic stk;
        logic unstk;
        logic data;
        logic fetch;
        logic [31:0] addr;
    } mfsf_evt_s;
endpackage : mfsf_pkg

// ### hw/mfsf_top.sv
// Memory fault status byte and captured fault address.
// Assumes fault events are single-cycle pulses from logic on i_mclk.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "mfsf_map.svh"
module mfsf_top (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire mfsf_pkg::mfsf_evt_s i_evt,
    input wire logic i_xn_fetch,
    input wire logic [`MFSF_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic [7:0] o_status
);
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [31:0] fault_addr_q;
    logic [31:0] fault_addr_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [7:0] set_v;
    logic [7:0] clr_v;

    // Execute-never fetches count regardless of protection enable
    logic fetch_ev;
    assign fetch_ev = i_evt.fetch | i_xn_fetch;

    // Event and clear vectors per flag position
    always_comb begin
        set_v = 8'h00;
        set_v[`MFSF_BIT_STK] = i_evt.stk;
        set_v[`MFSF_BIT_UNSTK] = i_evt.unstk;
        set_v[`MFSF_BIT_DATA] = i_evt.data;
        set_v[`MFSF_BIT_FETCH] = fetch_ev;
        // Only a data violation carries an address, so only it validates
        set_v[`MFSF_BIT_VALID] = i_evt.data;
        clr_v = 8'h00;
        if (i_wr && i_addr == `MFSF_OFF_STATUS) begin
            clr_v = i_wdata[7:0];
        end
    end

    // Set wins over clear; zeros written leave flags alone
    always_comb begin
        flags_d = ((flags_q & ~clr_v) | set_v) & ~`MFSF_RSVD_MASK;
        fault_addr_d = fault_addr_q;
        if (i_evt.data) begin
            fault_addr_d = i_evt.addr;
        end
        rdata_d = 32'h0000_0000;
        if (i_rd) begin
            case (i_addr)
                `MFSF_OFF_STATUS: rdata_d = {24'h00_0000, flags_q};
                `MFSF_OFF_ADDR: rdata_d = fault_addr_q;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // State registers
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            flags_q <= `MFSF_RST_STATUS;
            fault_addr_q <= `MFSF_RST_ADDR;
            rdata_q <= 32'h0000_0000;
        end else begin
            flags_q <= flags_d;
            fault_addr_q <= fault_addr_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_status = flags_q;

    flag_set_wins_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_evt.stk |=> flags_q[`MFSF_BIT_STK]) else $error("stack flag lost");
    unstk_set_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_evt.unstk |=> flags_q[`MFSF_BIT_UNSTK]) else $error("unstack flag lost");
    xn_fetch_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_xn_fetch |=> flags_q[`MFSF_BIT_FETCH]) else $error("xn fetch missed");
    data_capture_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_evt.data |=> (flags_q[`MFSF_BIT_DATA] && flags_q[`MFSF_BIT_VALID]
        && fault_addr_q == $past(i_evt.addr))) else $error("data capture wrong");
    valid_cause_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        $rose(flags_q[`MFSF_BIT_VALID]) |-> $past(i_evt.data)) else $error("valid without capture");
    no_capture_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        !i_evt.data |=> $stable(fault_addr_q)) else $error("address changed");
    rsvd_zero_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (flags_q & `MFSF_RSVD_MASK) == 8'h00) else $error("reserved bit set");
    w1c_clear_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_wr && i_addr == `MFSF_OFF_STATUS && i_wdata[`MFSF_BIT_STK] && !i_evt.stk)
        |=> !flags_q[`MFSF_BIT_STK]) else $error("w1c failed");
    write_zero_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_wr && !i_wdata[`MFSF_BIT_UNSTK] && flags_q[`MFSF_BIT_UNSTK])
        |=> flags_q[`MFSF_BIT_UNSTK]) else $error("write zero cleared");
    read_data_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_rd && i_addr == `MFSF_OFF_STATUS) |=> o_rdata[7:0] == $past(flags_q)) else $error("read wrong");
endmodule : mfsf_top
`default_nettype wire

// ### verification/mfsf_top_tb.sv
// Self-checking bench for the memory fault status byte and captured address.
// Assumes the map header and mfsf_top are compiled first; assertions sit in the design.
`timescale 1ns/1ps
`default_nettype none
`include "mfsf_map.svh"
module mfsf_top_tb;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    mfsf_pkg::mfsf_evt_s i_evt = '0;
    logic i_xn_fetch = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic [7:0] o_status;
    int errors = 0;
    int n_tests = 0;
    mfsf_top u_mfsf_top (.i_mclk(i_mclk), .i_rst(i_rst), .i_evt(i_evt), .i_xn_fetch(i_xn_fetch),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_status(o_status));
    // 200 MHz core clock
    always #2.5 i_mclk = ~i_mclk;
    // One-cycle request; settles past the next edge so both outputs are fresh
    task automatic step(input logic r, w, input logic [3:0] a, input logic [31:0] d, input logic [35:0] e,
                        input logic x);
        @(posedge i_mclk);
        {i_rd, i_wr, i_addr, i_wdata, i_evt, i_xn_fetch} <= {r, w, a, d, e, x};
        @(posedge i_mclk);
        {i_rd, i_wr, i_evt, i_xn_fetch} <= '0;
        #1;
    endtask : step
    task automatic cmp(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    // Data fault sets two bits and captures; one 0xFF write clears both
    task automatic t_data;
        step(0, 0, 4'h0, 32'h0, {4'h2, 32'hA5A5_0004}, 0);
        cmp(o_status, 8'h82);
        step(1, 0, `MFSF_OFF_ADDR, 32'h0, 36'h0, 0);
        cmp(o_rdata, 32'hA5A5_0004);
        step(0, 1, `MFSF_OFF_STATUS, 32'h0000_0064, 36'h0, 0);
        cmp(o_status, 8'h82);
        step(0, 1, `MFSF_OFF_STATUS, 32'h80, {4'h2, 32'hA5A5_0008}, 0);
        cmp(o_status, 8'h82);
        step(0, 1, `MFSF_OFF_STATUS, 32'hFF, 36'h0, 0);
        step(1, 0, `MFSF_OFF_STATUS, 32'h0, 36'h0, 0);
        cmp(o_rdata, 32'h0);
        $display("test data done");
    endtask : t_data
    // Other fault kinds never touch the captured address
    task automatic t_kinds;
        logic [3:0] ev[4] = '{4'h8, 4'h4, 4'h1, 4'h0};
        logic [7:0] ex[4] = '{8'h10, 8'h08, 8'h01, 8'h01};
        for (int i = 0; i < 4; i++) begin
            step(0, 0, 4'h0, 32'h0, {ev[i], 32'h0BAD_0000}, i == 3);
            cmp(o_status, ex[i]);
            step(1, 0, `MFSF_OFF_ADDR, 32'h0, 36'h0, 0);
            cmp(o_rdata, 32'hA5A5_0008);
            step(0, 1, `MFSF_OFF_STATUS, 32'hFF, 36'h0, 0);
            cmp(o_status, 8'h00);
        end
        step(1, 0, 4'hF, 32'h0, 36'h0, 0);
        cmp(o_rdata, 32'h0);
        $display("test kinds done");
    endtask : t_kinds
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    // Main sequence: reset held 20 cycles, then the scenarios
    initial begin
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        // Look after the first free edge so the flags are settled
        @(posedge i_mclk);
        #1;
        cmp(o_status, 8'h00);
        t_data();
        t_kinds();
        close_out();
    end
    // Watchdog at 4000 cycles, well beyond the 59 cycles the tests need
    initial begin
        #20us;
        errors++;
        close_out();
    end
endmodule : mfsf_top_tb
`default_nettype wire
